// ==== include/crc_pkg.sv ====
// Purpose: Shared constants and types for the programmable checksum engine.
// Assumes: Plain register port with one-cycle strobes and read data one cycle later.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package crc_pkg;

  localparam logic [7:0]  OFF_MODE   = 8'h00;
  localparam logic [7:0]  OFF_SEED   = 8'h04;
  localparam logic [7:0]  OFF_SUM    = 8'h08;
  localparam logic [7:0]  OFF_DATA   = 8'h0c;
  localparam logic [7:0]  OFF_STATUS = 8'h10;

  localparam int          MODE_POLY_LSB  = 0;
  localparam int          MODE_DREV_BIT  = 2;
  localparam int          MODE_DINV_BIT  = 3;
  localparam int          MODE_SREV_BIT  = 4;
  localparam int          MODE_SINV_BIT  = 5;
  localparam logic [5:0]  MODE_RESET     = 6'h00;
  localparam logic [31:0] SEED_RESET     = 32'hffffffff;

  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_16    = 16'h8005;
  localparam logic [31:0] POLY_32    = 32'h04c11db7;

  localparam logic [1:0]  SIZE_BYTE  = 2'h0;
  localparam logic [1:0]  SIZE_HALF  = 2'h1;
  localparam logic [1:0]  SIZE_WORD  = 2'h2;
  localparam logic [2:0]  STEPS_BYTE = 3'h1;
  localparam logic [2:0]  STEPS_HALF = 3'h2;
  localparam logic [2:0]  STEPS_WORD = 3'h4;

  typedef enum logic [1:0] {
    POLY_SEL_CCITT = 2'h0,
    POLY_SEL_16    = 2'h1,
    POLY_SEL_32    = 2'h2
  } poly_sel_t;

  // Fields run from bit 5 down to bit 0, matching the MODE_*_BIT positions.
  typedef struct packed {
    logic      sum_inv;
    logic      sum_rev;
    logic      data_inv;
    logic      data_rev;
    poly_sel_t poly;
  } mode_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [1:0]  size;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FOLD = 2'b01
  } fsm_t;

endpackage : crc_pkg

// ==== verilog/crc_byte_step.sv ====
// Purpose: Folds one byte into a running checksum with the selected polynomial.
// Assumes: Checksum kept MSB-first in the low bits for 16-bit selections.
// Notes:   Purely combinational.
`timescale 1ns/1ns
module crc_byte_step (
  input  wire crc_pkg::poly_sel_t poly,    // Polynomial selection
  input  wire logic [31:0]        sum_in,  // Checksum before the byte
  input  wire logic [7:0]         din,     // Byte to fold
  output logic [31:0]             sum_out  // Checksum after the byte
);
  import crc_pkg::*;

  always_comb begin
    logic [31:0] acc;
    logic        fb;
    acc = sum_in;
    fb  = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (poly == POLY_SEL_32) begin
        fb  = acc[31] ^ din[i];
        acc = {acc[30:0], 1'b0} ^ (fb ? POLY_32 : 32'h00000000);
      end else begin
        fb  = acc[15] ^ din[i];
        acc = {16'h0000, acc[14:0], 1'b0} ^ {16'h0000, fb ? ((poly == POLY_SEL_16) ? POLY_16 : POLY_CCITT) : 16'h0000};
      end
    end
    sum_out = acc;
  end

endmodule : crc_byte_step

// ==== verilog/crc_bit_mirror.sv ====
// Purpose: Optional bit reversal and inversion of a word of a given width.
// Assumes: Width is a parameter; used for data bytes and the checksum.
// Notes:   Purely combinational.
`timescale 1ns/1ns
module crc_bit_mirror #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] din,  // Value in
  input  wire logic         rev,  // Reverse bit order
  input  wire logic         inv,  // Invert every bit
  output logic [W-1:0]      dout  // Value out
);

  always_comb begin
    logic [W-1:0] t;
    t = din;
    if (rev) begin
      for (int i = 0; i < W; i++) t[i] = din[W-1-i];
    end
    dout = inv ? ~t : t;
  end

endmodule : crc_bit_mirror

// ==== verilog/crc_engine.sv ====
// Purpose: Programmable checksum engine fed by processor or DMA writes.
// Assumes: Register strobes one cycle, read data one cycle later, no wait states.
// Notes:   A busy engine defers a read or data write until its byte steps end.
//
// Notes on behaviour
// R1: Checksum uses one of three software-selected polynomials.
// R2: CCITT selection folds with x16+x12+x5+1 into 16 bits.
// R3: CRC-16 selection folds with x16+x15+x2+1 into 16 bits.
// R4: CRC-32 selection folds with the standard 32-bit polynomial.
// R5: Separate bit-reverse settings for input data and for read checksum.
// R6: Separate invert settings for input data and for read checksum.
// R7: Software loads a seed into the accumulator before calculating.
// R8: Two back-to-back data writes accepted without idle bus cycles; one request parks while busy, later ones overwrite it or are dropped.
// R9: Byte, halfword or word writes fold exactly the written bytes.
// R10: A byte write completes in one cycle.
// R11: A halfword write completes in two byte steps, two cycles.
// R12: A word write completes in four byte steps, four cycles.
// R13: Multi-byte writes fold least significant byte first.
// R14: Reads and later data writes wait until prior byte steps end.
`timescale 1ns/1ns
module crc_engine (
  input  wire logic              sys_clk,  // 50 MHz clock
  input  wire logic              arst_n,   // Asynchronous reset, active low
  input  wire crc_pkg::bus_req_t req,      // Address, data, size and strobes
  output logic [31:0]            rdata,    // Read data, valid the cycle after an idle engine takes a read
  output logic                   busy      // Byte steps still in progress
);
  import crc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  mode_t       mode, next_mode;
  logic [31:0] seed, next_seed;
  logic [31:0] sum, next_sum;
  logic [31:0] word, next_word;
  logic [2:0]  left, next_left;
  fsm_t        state, next_state;
  bus_req_t    held, next_held;
  logic        held_ok, next_held_ok;
  logic [31:0] next_rdata;
  logic        next_busy;

  // ****************************************
  // Datapath
  // ****************************************
  logic [7:0]  byte_raw, byte_in;
  logic [31:0] step_sum;
  logic [31:0] sum_view, sum_fmt16, sum_fmt32;

  assign byte_raw = word[7:0]; // R13

  crc_bit_mirror #(.W(8)) u_din (
    .din  (byte_raw),
    .rev  (mode.data_rev),
    .inv  (mode.data_inv),
    .dout (byte_in)
  ); // R5 R6

  crc_byte_step u_step (
    .poly    (mode.poly),
    .sum_in  (sum),
    .din     (byte_in),
    .sum_out (step_sum)
  ); // R1 R2 R3 R4

  crc_bit_mirror #(.W(32)) u_s32 (
    .din  (sum),
    .rev  (mode.sum_rev),
    .inv  (mode.sum_inv),
    .dout (sum_fmt32)
  ); // R5 R6

  crc_bit_mirror #(.W(16)) u_s16 (
    .din  (sum[15:0]),
    .rev  (mode.sum_rev),
    .inv  (mode.sum_inv),
    .dout (sum_fmt16[15:0])
  ); // R5 R6

  assign sum_fmt16[31:16] = 16'h0000;
  assign sum_view = (mode.poly == POLY_SEL_32) ? sum_fmt32 : sum_fmt16;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    bus_req_t r;
    logic     take;
    next_mode    = mode;
    next_seed    = seed;
    next_sum     = sum;
    next_word    = word;
    next_left    = left;
    next_state   = state;
    next_held    = held;
    next_held_ok = held_ok;
    next_rdata   = 32'h00000000;
    take         = 1'b0;
    r            = req;

    // A request arriving while busy is parked and served after the last step.
    if (state == ST_FOLD) begin
      next_sum  = step_sum;
      next_word = {8'h00, word[31:8]}; // R13
      next_left = left - 3'h1;
      if (req.wr || req.rd) begin
        next_held    = req; // R14
        next_held_ok = 1'b1;
      end
      if (left == 3'h1) begin
        next_state = ST_IDLE;
      end
    end

    if (state == ST_IDLE && held_ok) begin
      r            = held;
      take         = 1'b1;
      next_held_ok = 1'b0;
    end else if (state == ST_IDLE) begin
      r    = req;
      take = req.wr || req.rd;
    end else begin
      r = req;
    end

    if (take && r.wr) begin
      case (r.addr)
        OFF_MODE: begin
          next_mode = mode_t'(r.wdata[5:0]); // R1
        end
        OFF_SEED: begin
          next_seed = r.wdata;
          next_sum  = r.wdata; // R7
        end
        OFF_DATA: begin
          next_word  = r.wdata; // R8 R9
          next_state = ST_FOLD;
          case (r.size)
            SIZE_HALF: next_left = STEPS_HALF; // R11
            SIZE_WORD: next_left = STEPS_WORD; // R12
            default:   next_left = STEPS_BYTE; // R10
          endcase
        end
        default: begin
        end
      endcase
    end
    if (take && r.rd) begin
      case (r.addr)
        OFF_MODE:   next_rdata = {26'h0000000, mode};
        OFF_SEED:   next_rdata = seed;
        OFF_SUM:    next_rdata = sum_view; // R14
        OFF_STATUS: next_rdata = {31'h00000000, held_ok};
        default:    next_rdata = 32'h00000000;
      endcase
    end
    next_busy = (next_state == ST_FOLD);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode    <= mode_t'(MODE_RESET);
      seed    <= SEED_RESET;
      sum     <= SEED_RESET;
      word    <= 32'h00000000;
      left    <= 3'h0;
      state   <= ST_IDLE;
      held    <= '0;
      held_ok <= 1'b0;
      rdata   <= 32'h00000000;
      busy    <= 1'b0;
    end else begin
      mode    <= next_mode;
      seed    <= next_seed;
      sum     <= next_sum;
      word    <= next_word;
      left    <= next_left;
      state   <= next_state;
      held    <= next_held;
      held_ok <= next_held_ok;
      rdata   <= next_rdata;
      busy    <= next_busy;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_word_write;
    state == ST_IDLE && !held_ok && req.wr && req.addr == OFF_DATA && req.size == SIZE_WORD;
  endsequence

  sequence s_half_write;
    state == ST_IDLE && !held_ok && req.wr && req.addr == OFF_DATA && req.size == SIZE_HALF;
  endsequence

  sequence s_byte_write;
    state == ST_IDLE && !held_ok && req.wr && req.addr == OFF_DATA && req.size == SIZE_BYTE;
  endsequence

  a_word_four_steps: assert property (@(posedge sys_clk) disable iff (!arst_n) // R12
    s_word_write |=> (state == ST_FOLD) [*4] ##1 state == ST_IDLE)
    else $error("word write did not take four steps");

  a_half_two_steps: assert property (@(posedge sys_clk) disable iff (!arst_n) // R11
    s_half_write |=> (state == ST_FOLD) [*2] ##1 state == ST_IDLE)
    else $error("halfword write did not take two steps");

  a_byte_one_step: assert property (@(posedge sys_clk) disable iff (!arst_n) // R10
    s_byte_write |=> state == ST_FOLD ##1 state == ST_IDLE)
    else $error("byte write did not take one step");

  a_seed_loads_sum: assert property (@(posedge sys_clk) disable iff (!arst_n) // R7
    state == ST_IDLE && !held_ok && req.wr && req.addr == OFF_SEED |=> sum == $past(req.wdata))
    else $error("seed write did not load accumulator");

  a_low_byte_first: assert property (@(posedge sys_clk) disable iff (!arst_n) // R13
    s_half_write |=> byte_raw == $past(req.wdata[7:0]) ##1 byte_raw == $past(req.wdata[15:8], 2))
    else $error("bytes not folded low first");

  a_busy_matches: assert property (@(posedge sys_clk) disable iff (!arst_n) // R14
    busy == (left != 3'h0))
    else $error("busy flag disagrees with engine state");

  a_parked_served: assert property (@(posedge sys_clk) disable iff (!arst_n) // R8
    held_ok && state == ST_IDLE |=> !held_ok || state == ST_FOLD)
    else $error("parked request not served");

  a_mode_written: assert property (@(posedge sys_clk) disable iff (!arst_n) // R1
    state == ST_IDLE && !held_ok && req.wr && req.addr == OFF_MODE |=> mode == mode_t'($past(req.wdata[5:0])))
    else $error("mode write not stored");

  a_sum_read: assert property (@(posedge sys_clk) disable iff (!arst_n) // R5
    state == ST_IDLE && !held_ok && req.rd && req.addr == OFF_SUM |=> rdata == $past(sum_view))
    else $error("checksum read wrong");

  a_quiet_while_busy: assert property (@(posedge sys_clk) disable iff (!arst_n) // R14
    state == ST_FOLD |=> rdata == 32'h00000000)
    else $error("read data shown while busy");

  a_request_parked: assert property (@(posedge sys_clk) disable iff (!arst_n) // R14
    state == ST_FOLD && (req.wr || req.rd) |=> held_ok && held == $past(req))
    else $error("request during steps not parked");

  a_sum16_upper_zero: assert property (@(posedge sys_clk) disable iff (!arst_n) // R2
    state == ST_FOLD && mode.poly != POLY_SEL_32 |=> sum[31:16] == 16'h0000)
    else $error("16-bit checksum left upper bits set");

endmodule : crc_engine

// ==== tb/bus_master_model.sv ====
// Purpose: Bus master model, a processor or DMA channel writing the engine.
// Assumes: Calls are made just after a rising edge of sys_clk.
// Notes:   A request stays up until the next request or idle replaces it.
`timescale 1ns/1ns
module bus_master_model (
  input  wire logic         sys_clk, // Clock
  output crc_pkg::bus_req_t req      // Request to the engine
);
  import crc_pkg::*;
  initial req = '0;
  // Requests may follow each other with no idle cycle between them.
  task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [1:0] s, input logic w);
    req <= '{addr: a, wdata: d, size: s, wr: w, rd: !w};
    @(posedge sys_clk);
  endtask : put
  task automatic idle();
    req <= '0;
  endtask : idle
endmodule : bus_master_model

// ==== tb/crc_engine_tb.sv ====
// Purpose: Self-checking bench for the checksum engine.
// Assumes: Non-reflected shift; 16-bit selections use the low half.
// Notes:   Expected sums come from a byte-serial reference model.
`timescale 1ns/1ns
module crc_engine_tb;
  import crc_pkg::*;
  logic        sys_clk;
  logic        arst_n;
  bus_req_t    req;
  logic [31:0] rdata;
  logic        busy;
  int          fails;
  int          total_checks;
  int          n;
  logic [31:0] acc;
  logic [31:0] got;
  logic [31:0] seed;
  logic [31:0] dat;
  logic [5:0]  mode;
  logic [1:0]  sz [3] = '{SIZE_WORD, SIZE_HALF, SIZE_BYTE};
  int          nb [3] = '{4, 2, 1};

  crc_engine u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .req(req), .rdata(rdata), .busy(busy));
  bus_master_model u_mst (.sys_clk(sys_clk), .req(req));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Reference model and helpers
  // ****************************************
  function automatic logic [31:0] rev32(input logic [31:0] x);
    for (int k = 0; k < 32; k++) rev32[k] = x[31-k];
  endfunction : rev32

  function automatic logic [31:0] fold(input logic [31:0] s, input logic [31:0] d, input int cnt,
                                       input logic [5:0] m);
    logic [7:0]  b;
    logic [31:0] r;
    logic [15:0] t;
    logic [15:0] p;
    p = (m[1:0] == POLY_SEL_CCITT) ? POLY_CCITT : POLY_16;
    for (int j = 0; j < cnt; j++) begin
      b = d[8*j +: 8];
      r = rev32({24'h0, b});
      if (m[MODE_DREV_BIT]) b = r[31:24];
      if (m[MODE_DINV_BIT]) b = ~b;
      if (m[1:0] == POLY_SEL_32) begin
        s = s ^ {b, 24'h0};
        for (int k = 0; k < 8; k++) s = s[31] ? ((s << 1) ^ POLY_32) : (s << 1);
      end else begin
        t = s[15:0] ^ {b, 8'h0};
        for (int k = 0; k < 8; k++) t = t[15] ? ((t << 1) ^ p) : (t << 1);
        s = {16'h0, t};
      end
    end
    return s;
  endfunction : fold

  function automatic logic [31:0] view(input logic [31:0] s, input logic [5:0] m);
    logic [31:0] r;
    logic [15:0] t;
    if (m[1:0] == POLY_SEL_32) begin
      r = m[MODE_SREV_BIT] ? rev32(s) : s;
      return m[MODE_SINV_BIT] ? ~r : r;
    end
    r = rev32({16'h0, s[15:0]});
    t = m[MODE_SREV_BIT] ? r[31:16] : s[15:0];
    return {16'h0, m[MODE_SINV_BIT] ? ~t : t};
  endfunction : view

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wait_idle(output int cnt);
    cnt = 0;
    u_mst.idle();
    @(posedge sys_clk);
    while (busy !== 1'b0) begin
      cnt++;
      if (cnt > 20) begin
        fails++;
        final_report();
      end
      @(posedge sys_clk);
    end
  endtask : wait_idle

  // A read made while busy is served on the first idle cycle, data one cycle later.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic b;
    int   k;
    u_mst.put(a, 32'h0, SIZE_BYTE, 1'b0);
    b = busy;
    k = 0;
    u_mst.idle();
    while (b !== 1'b0) begin
      @(posedge sys_clk);
      b = busy;
      k++;
      if (k > 20) begin
        fails++;
        final_report();
      end
    end
    @(posedge sys_clk);
    v = rdata;
  endtask : rd

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd(OFF_MODE, got);
    chk("mode reset", {26'h0, MODE_RESET}, got);
    rd(OFF_SEED, got);
    chk("seed reset", SEED_RESET, got);
    rd(8'h14, got);
    chk("unmapped read", 32'h0, got);
    rd(OFF_STATUS, got);
    chk("status idle", 32'h0, got);
    $display("reset test done");
    for (int i = 0; i < 48; i++) begin
      mode = {4'(i / 3), 2'(i % 3)};
      seed = 32'h1d0f5a3c ^ (i * 32'h01010101);
      dat = 32'h3c96e107 + i * 32'h04070b0d;
      u_mst.put(OFF_MODE, {26'h0, mode}, SIZE_WORD, 1'b1);
      u_mst.put(OFF_SEED, seed, SIZE_WORD, 1'b1);
      wait_idle(n);
      rd(OFF_MODE, got);
      chk("mode", {26'h0, mode}, got);
      acc = (mode[1:0] == POLY_SEL_32) ? seed : {16'h0, seed[15:0]};
      for (int j = 0; j < 3; j++) begin
        u_mst.put(OFF_DATA, dat + j * 32'h11111111, sz[j], 1'b1);
        wait_idle(n);
        chk("step cycles", 32'(nb[j]), 32'(n));
        acc = fold(acc, dat + j * 32'h11111111, nb[j], mode);
      end
      u_mst.put(OFF_DATA, ~dat, SIZE_WORD, 1'b1);
      u_mst.put(OFF_DATA, dat ^ 32'h5a5a5a5a, SIZE_BYTE, 1'b1);
      wait_idle(n);
      wait_idle(n);
      acc = fold(fold(acc, ~dat, 4, mode), dat ^ 32'h5a5a5a5a, 1, mode);
      u_mst.put(OFF_DATA, {dat[15:0], dat[31:16]}, SIZE_HALF, 1'b1);
      rd(OFF_SUM, got);
      acc = fold(acc, {dat[15:0], dat[31:16]}, 2, mode);
      chk("checksum", view(acc, mode), got);
    end
    $display("mode sweep test done");
    u_mst.put(OFF_SUM, 32'h0, SIZE_WORD, 1'b1);
    wait_idle(n);
    rd(OFF_SUM, got);
    chk("read-only sum", view(acc, mode), got);
    $display("read-only test done");
    final_report();
  end
endmodule : crc_engine_tb
